// ===== core/breaker_telemetry.sv
// Telemetry frame packer and remote acknowledge handler
// Summary of operation
// - Frame 29 low byte carries phase shift, decoupling, asymmetry, rotation mismatch flags.
// - Frame 29 bytes 3 to 6 carry signed system A active power in watts.
// - Frame 30 bytes 1 to 2 carry the second system A flag word.
// - Flag word two holds rate-of-change, time-dependent voltage and voltage increase trips.
// - Flag word two low bits: breaker A unload mismatch, reactive undervoltage steps.
// - Frame 30 bytes 3 to 6 carry signed system B active power in watts.
// - Remote control writes are accepted with no password or access level.
// - Remote control data is volatile and returns to reset after power-up.
// - Control word one is a writable 16-bit object at its object index.
// - Acknowledge bit drives the remote acknowledge command variable.
// - First rising edge silences horn, second rising edge resets alarms.
// - Remote acknowledge variable mirrors the written acknowledge bit one cycle after each write to control word one.
// - Alarm reset clears only alarms no longer active; active ones stay latched.
`timescale 1ns/1ps
`default_nettype none
module breaker_telemetry
  import breaker_telemetry_pkg::*;
#(
  parameter int ALARM_W = 16
)(
  // Clock and reset
  input  wire  logic               mclk,
  input  wire  logic               rst_n,
  // Monitoring inputs, same clock domain
  input  wire  logic [7:0]         sys_a_flags_one_low,
  input  wire  logic [15:0]        sys_a_flags_two,
  input  wire  logic signed [31:0] sys_a_power,
  input  wire  logic signed [31:0] sys_b_power,
  // Frame request
  input  wire  logic               frame_req,
  input  wire  logic [7:0]         frame_mux,
  output logic                     frame_valid,
  output logic [7:0]               frame_mux_out,
  output logic [8*FRAME_BYTES-1:0] frame_data,
  // Object read and write port
  input  wire  logic               obj_wr,
  input  wire  logic [15:0]        obj_index,
  input  wire  logic [15:0]        obj_wdata,
  input  wire  logic               obj_rd,
  output logic [15:0]              obj_rdata,
  output logic                     obj_ack,
  // Alarm sources and acknowledge outputs
  input  wire  logic [ALARM_W-1:0] alarm_active,
  output logic [ALARM_W-1:0]       alarm_latched,
  output logic                     remote_ack_var,
  output logic                     horn_on
);

  // Alarm width must fit the latch logic
  generate
    if (ALARM_W < 1 || ALARM_W > 64)
    begin : g_bad_alarm_w
      $error("ALARM_W out of range");
    end
  endgenerate

  // Control word and acknowledge state
  logic [15:0]              ctrl_word_q;
  logic [15:0]              ctrl_word_d;
  ack_state_t               ack_state_q;
  ack_state_t               ack_state_d;
  // Object port decode
  logic                     obj_hit;
  logic                     obj_wr_hit;
  logic                     obj_rd_hit;
  // Acknowledge events
  logic                     ack_held;
  logic                     ack_edge;
  logic                     horn_silence;
  logic                     alarm_clear;
  logic                     alarm_new;
  // Frame assembly
  logic                     frame_a_sel;
  logic                     frame_b_sel;
  logic                     frame_take;
  logic [7:0]               flags_one_filt;
  logic [15:0]              flags_two_filt;
  logic [8*FRAME_BYTES-1:0] frame_a_payload;
  logic [8*FRAME_BYTES-1:0] frame_b_payload;
  logic [8*FRAME_BYTES-1:0] frame_next;

  // Keep documented bits only, internal bits go out as zero
  assign flags_one_filt = sys_a_flags_one_low &
                          (F1_PHASE_SHIFT | F1_DECOUPLING | F1_ASYMMETRY | F1_ROTATION);
  assign flags_two_filt = sys_a_flags_two &
                          (F2_FREQ_ROC | F2_TIME_VOLTAGE | F2_VOLT_INCREASE
                           | F2_BREAKER_A_UNLOAD | F2_RUV_STEP1 | F2_RUV_STEP2);

  // Frame request decode, other mux numbers are ignored
  assign frame_a_sel = frame_req && (frame_mux == MUX_SYS_A_POWER);
  assign frame_b_sel = frame_req && (frame_mux == MUX_SYS_B_POWER);
  assign frame_take  = frame_a_sel || frame_b_sel;

  // Frame 29 payload, byte 1 in the low lane
  always_comb
  begin
    frame_a_payload        = '0;
    frame_a_payload[7:0]   = flags_one_filt;
    frame_a_payload[15:8]  = 8'h00;
    frame_a_payload[47:16] = sys_a_power;
  end

  // Frame 30 payload, flag word low byte first
  always_comb
  begin
    frame_b_payload        = '0;
    frame_b_payload[7:0]   = flags_two_filt[7:0];
    frame_b_payload[15:8]  = flags_two_filt[15:8];
    frame_b_payload[47:16] = sys_b_power;
  end

  // Payload select
  always_comb
  begin
    if (frame_b_sel)
    begin
      frame_next = frame_b_payload;
    end
    else
    begin
      frame_next = frame_a_payload;
    end
  end

  // Frame strobe, one cycle per accepted request
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      frame_valid <= 1'b0;
    end
    else
    begin
      frame_valid <= frame_take;
    end
  end

  // Mux number of the last frame, held until the next one
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      frame_mux_out <= 8'h00;
    end
    else if (frame_take)
    begin
      frame_mux_out <= frame_mux;
    end
  end

  // Frame payload, held until the next frame
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      frame_data <= '0;
    end
    else if (frame_take)
    begin
      frame_data <= frame_next;
    end
  end

  // Object decode; the parameter number is an alias of the index
  assign obj_hit    = (obj_index == OBJ_CTRL_WORD_ONE) || (obj_index == PARAM_CTRL_WORD_ONE);
  assign obj_wr_hit = obj_wr && obj_hit;
  assign obj_rd_hit = obj_rd && obj_hit;

  // Unused bits are dropped so they can never act
  assign ctrl_word_d = obj_wdata & CTRL_USED_MASK;

  // Acknowledge bit as last written, reference for edge detection
  assign ack_held = ctrl_word_q[ACK_BIT];

  // Rising edge: written one over held zero
  assign ack_edge = obj_wr_hit && obj_wdata[ACK_BIT] && !ack_held;

  // Acknowledge events
  always_comb
  begin
    horn_silence = ack_edge && (ack_state_q == ACK_IDLE);
    alarm_clear  = ack_edge && (ack_state_q == ACK_HORN_OFF);
    alarm_new    = |(alarm_active & ~alarm_latched);
  end

  // Control word, volatile, no access check
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ctrl_word_q <= CTRL_WORD_RESET;
    end
    else if (obj_wr_hit)
    begin
      ctrl_word_q <= ctrl_word_d;
    end
  end

  // Object acknowledge, one cycle after a hit
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      obj_ack <= 1'b0;
    end
    else
    begin
      obj_ack <= obj_wr_hit || obj_rd_hit;
    end
  end

  // Read data, held until the next read
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      obj_rdata <= 16'h0000;
    end
    else if (obj_rd_hit)
    begin
      obj_rdata <= ctrl_word_q;
    end
  end

  // Command variable mirror, one cycle after the write
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      remote_ack_var <= 1'b0;
    end
    else if (obj_wr_hit)
    begin
      remote_ack_var <= obj_wdata[ACK_BIT];
    end
  end

  // Two-edge acknowledge sequence
  always_comb
  begin
    ack_state_d = ack_state_q;
    if (ack_edge)
    begin
      case (ack_state_q)
        ACK_IDLE:
        begin
          ack_state_d = ACK_HORN_OFF;
        end
        ACK_HORN_OFF:
        begin
          ack_state_d = ACK_IDLE;
        end
        default:
        begin
          ack_state_d = ACK_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ack_state_q <= ACK_IDLE;
    end
    else
    begin
      ack_state_q <= ack_state_d;
    end
  end

  // One latch per alarm; a new alarm wins over a clear
  for (genvar i = 0; i < ALARM_W; i++)
  begin : g_alarm
    always_ff @(posedge mclk)
    begin
      if (!rst_n)
      begin
        alarm_latched[i] <= 1'b0;
      end
      else if (alarm_active[i])
      begin
        alarm_latched[i] <= 1'b1;
      end
      else if (alarm_clear)
      begin
        alarm_latched[i] <= 1'b0;
      end
    end
  end

  // Horn sounds for any unlatched alarm; silencing loses to a new alarm
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      horn_on <= 1'b0;
    end
    else if (alarm_new)
    begin
      horn_on <= 1'b1;
    end
    else if (horn_silence)
    begin
      horn_on <= 1'b0;
    end
  end

endmodule // breaker_telemetry
`default_nettype wire

// ===== core/breaker_telemetry_pkg.sv
// Constants for the breaker telemetry framer and remote acknowledge block
package breaker_telemetry_pkg;
  // Multiplex frame numbers
  localparam logic [7:0]  MUX_SYS_A_POWER    = 8'h1d;
  localparam logic [7:0]  MUX_SYS_B_POWER    = 8'h1e;
  // Frame payload width: six data bytes, byte 1 first
  localparam int          FRAME_BYTES        = 6;
  // Object address of remote control word one
  localparam logic [15:0] OBJ_CTRL_WORD_ONE  = 16'h21f7;
  localparam logic [15:0] PARAM_CTRL_WORD_ONE = 16'h01f7;
  localparam logic [15:0] CTRL_WORD_RESET    = 16'h0000;
  // Control word bit positions
  localparam int          ACK_BIT            = 4;
  localparam logic [15:0] CTRL_USED_MASK     = 16'h0010;
  // Flag word one low byte masks
  localparam logic [7:0]  F1_PHASE_SHIFT     = 8'h80;
  localparam logic [7:0]  F1_DECOUPLING      = 8'h40;
  localparam logic [7:0]  F1_ASYMMETRY       = 8'h08;
  localparam logic [7:0]  F1_ROTATION        = 8'h04;
  // Flag word two masks
  localparam logic [15:0] F2_FREQ_ROC        = 16'h0080;
  localparam logic [15:0] F2_TIME_VOLTAGE    = 16'h0020;
  localparam logic [15:0] F2_VOLT_INCREASE   = 16'h0008;
  localparam logic [15:0] F2_BREAKER_A_UNLOAD = 16'h0004;
  localparam logic [15:0] F2_RUV_STEP1       = 16'h0002;
  localparam logic [15:0] F2_RUV_STEP2       = 16'h0001;
  typedef enum logic [1:0] {ACK_IDLE, ACK_HORN_OFF} ack_state_t;
endpackage

// ===== test/breaker_telemetry_props.sv
// Port checker for the breaker telemetry block
`timescale 1ns/1ps
`default_nettype none
module breaker_telemetry_props (
  // Watched ports
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        frame_req,
  input wire logic [7:0]  frame_mux,
  input wire logic        frame_valid,
  input wire logic [7:0]  frame_mux_out,
  input wire logic        obj_wr,
  input wire logic        obj_rd,
  input wire logic [15:0] obj_index,
  input wire logic [15:0] obj_wdata,
  input wire logic [15:0] obj_rdata,
  input wire logic        obj_ack,
  input wire logic        remote_ack_var
);
  logic hit;
  logic take;
  assign hit  = (obj_wr || obj_rd) && (obj_index == 16'h21f7 || obj_index == 16'h01f7);
  assign take = frame_req && (frame_mux == 8'h1d || frame_mux == 8'h1e);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence wr_hit; hit && obj_wr; endsequence
  sequence rd_hit; hit && obj_rd && !obj_wr; endsequence
  frame_pulse_a: assert property (frame_valid == $past(take)) else $error("frame valid wrong");
  frame_mux_a: assert property (take |=> frame_mux_out == $past(frame_mux)) else $error("frame mux wrong");
  mux_hold_a: assert property (!take |=> $stable(frame_mux_out)) else $error("frame mux moved");
  obj_ack_a: assert property (obj_ack == $past(hit)) else $error("object ack wrong");
  ack_mirror_a: assert property (wr_hit |=> remote_ack_var == $past(obj_wdata[4])) else $error("mirror wrong");
  mirror_hold_a: assert property (!hit |=> $stable(remote_ack_var)) else $error("mirror moved");
  unused_zero_a: assert property ((obj_rdata & 16'hffef) == 16'h0000) else $error("unused bit set");
  read_back_a: assert property (rd_hit |=> obj_rdata[4] == $past(remote_ack_var)) else $error("read wrong");
endmodule // breaker_telemetry_props
bind breaker_telemetry breaker_telemetry_props breaker_telemetry_props_i (.*);
`default_nettype wire

// ===== test/remote_ctrl_model.sv
// Remote controller model driving the object port
`timescale 1ns/1ps
`default_nettype none
module remote_ctrl_model (
  // Clock and object port
  input  wire logic  mclk,
  output logic       obj_wr = 1'b0,
  output logic       obj_rd = 1'b0,
  output logic [15:0] obj_index = 16'h0000,
  output logic [15:0] obj_wdata = 16'h0000
);
  task automatic access(input bit wr, input logic [15:0] idx, input logic [15:0] d);
    @(posedge mclk);
    obj_wr    <= wr;
    obj_rd    <= !wr;
    obj_index <= idx;
    obj_wdata <= d & 16'hfff3;
    @(posedge mclk);
    obj_wr    <= 1'b0;
    obj_rd    <= 1'b0;
    obj_wdata <= ~obj_wdata & 16'hfff3;
    #1;
  endtask
endmodule // remote_ctrl_model
`default_nettype wire

// ===== test/breaker_telemetry_tb.sv
// Self-checking bench for the breaker telemetry block
`timescale 1ns/1ps
`default_nettype none
module breaker_telemetry_tb;
  logic mclk = 0, rst_n = 0, frame_req = 0, frame_valid, obj_wr, obj_rd, obj_ack, remote_ack_var, horn_on;
  logic [7:0] sys_a_flags_one_low = 0, frame_mux = 0, frame_mux_out;
  logic [15:0] sys_a_flags_two = 0, obj_index, obj_wdata, obj_rdata, alarm_active = 0, alarm_latched;
  logic signed [31:0] sys_a_power = 0, sys_b_power = 0;
  logic [47:0] frame_data, exp;
  int err_total, n_compared, held, edges;
  always #5 mclk = ~mclk;
  breaker_telemetry breaker_telemetry_i (.*);
  remote_ctrl_model remote_ctrl_model_i (.*);
  task automatic chk(input bit ok);
    n_compared++;
    if (!ok)
    begin
      err_total++;
      $display("ERROR %0t mismatch", $time);
    end
  endtask
  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic frame(input logic [7:0] m, input bit ok);
    @(posedge mclk);
    frame_req <= 1'b1;
    frame_mux <= m;
    @(posedge mclk);
    frame_req <= 1'b0;
    #1 chk(frame_valid === ok && (!ok || frame_data === exp));
  endtask
  task automatic wr(input logic [15:0] idx, input logic [15:0] d, input bit hit);
    remote_ctrl_model_i.access(1'b1, idx, d);
    chk(obj_ack === hit);
    if (hit)
    begin
      edges += d[4] && !held;
      held = d[4];
      chk(remote_ack_var === d[4]);
    end
  endtask
  initial
  begin
    #100us err_total++;
    summarize();
  end
  initial
  begin
    void'($urandom(32'h05ccbfab));
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4)
    begin
      @(posedge mclk);
      {sys_a_flags_one_low, sys_a_flags_two} <= 24'($urandom);
      {sys_a_power, sys_b_power} <= {$urandom, $urandom};
      #1 exp = {sys_a_power, 8'h00, sys_a_flags_one_low & 8'hcc};
      frame(8'h1d, 1'b1);
      exp = {sys_b_power, sys_a_flags_two & 16'h00af};
      frame(8'h1e, 1'b1);
    end
    frame(8'h1f, 1'b0);
    $display("frames done");
    wr(16'h21f7, 16'hffff, 1'b1);
    remote_ctrl_model_i.access(1'b0, 16'h01f7, 16'h0000);
    chk(obj_rdata === 16'h0010);
    wr(16'h21f8, 16'h0000, 1'b0);
    $display("object done");
    @(posedge mclk);
    rst_n <= 1'b0;
    alarm_active <= 16'h0003;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    held = 0;
    edges = 0;
    #1 chk(obj_rdata === 16'h0000 && remote_ack_var === 1'b0);
    repeat (2) @(posedge mclk);
    alarm_active <= 16'h0001;
    #1 chk(horn_on === 1'b1 && alarm_latched === 16'h0003);
    for (int i = 0; i < 4; i++)
    begin
      wr(16'h21f7, i[0] ? 16'h0010 : 16'h0000, 1'b1);
      chk(horn_on === (edges == 0) && alarm_latched === (edges == 2 ? 16'h0001 : 16'h0003));
    end
    $display("acknowledge done");
    summarize();
  end
endmodule // breaker_telemetry_tb
`default_nettype wire
